// ==== design/tpf_pkg.sv ====
// Shared constants, register map and parity helpers for the triple port queue block
package tpf_pkg;

  // Data path geometry
  localparam int unsigned LANE_W = 9;
  localparam int unsigned A_LANES = 4;
  localparam int unsigned A_W = 36;
  localparam int unsigned HALF_W = 18;
  localparam int unsigned QUEUE_DEPTH = 64;
  localparam int unsigned MIN_DEPTH = 17;

  // Flag offsets, indexed by {offset_select_hi, offset_select_lo}
  localparam logic [6:0] OFFSET_SEL_00 = 7'h04;
  localparam logic [6:0] OFFSET_SEL_01 = 7'h08;
  localparam logic [6:0] OFFSET_SEL_10 = 7'h0c;
  localparam logic [6:0] OFFSET_SEL_11 = 7'h10;
  localparam logic [6:0] OFFSET_RESET = 7'h04;

  // APB register byte addresses
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT = 12'h008;

  // Control register fields and reset value
  localparam int unsigned CTRL_PAR_IGNORE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register field positions
  localparam int unsigned ST_A_EMPTY_BIT = 0;
  localparam int unsigned ST_A_FULL_BIT = 1;
  localparam int unsigned ST_A_AEMPTY_BIT = 2;
  localparam int unsigned ST_A_AFULL_BIT = 3;
  localparam int unsigned ST_B_EMPTY_BIT = 4;
  localparam int unsigned ST_B_AEMPTY_BIT = 5;
  localparam int unsigned ST_C_FULL_BIT = 6;
  localparam int unsigned ST_C_AFULL_BIT = 7;
  localparam int unsigned ST_PAR_ERR_BIT = 8;
  localparam int unsigned ST_OFFSET_LSB = 16;

  // Count register field positions
  localparam int unsigned CNT_AB_LSB = 0;
  localparam int unsigned CNT_CA_LSB = 16;

  // Lane passes when its ones count matches the selected polarity
  function automatic logic lane_ok(input logic [8:0] lane, input logic odd);
    return (^lane) == odd;
  endfunction

  // Parity bit that makes the lane match the selected polarity
  function automatic logic gen_bit(input logic [7:0] data, input logic odd);
    return (^data) ^ odd;
  endfunction

  // Preset table for the two offset select straps
  function automatic logic [6:0] offset_of(input logic [1:0] sel);
    logic [6:0] r;
    r = OFFSET_SEL_00;
    unique case (sel)
      2'h0: r = OFFSET_SEL_00;
      2'h1: r = OFFSET_SEL_01;
      2'h2: r = OFFSET_SEL_10;
      2'h3: r = OFFSET_SEL_11;
    endcase
    return r;
  endfunction

endpackage

// ==== design/tpf_queue_if.sv ====
// Connection between the top level and one queue instance
`timescale 1ns/1ps
interface tpf_queue_if #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 64
);
  localparam int unsigned CW = $clog2(DEPTH) + 1;

  // Write side
  logic wr_tick;
  logic wr_en;
  logic [WIDTH-1:0] wr_data;
  // Read side
  logic rd_tick;
  logic rd_en;
  logic [WIDTH-1:0] rd_data;
  // Status
  logic [CW-1:0] offset;
  logic [CW-1:0] count;
  logic empty_n;
  logic full_n;
  logic aempty_n;
  logic afull_n;

  modport queue (
    input wr_tick, wr_en, wr_data, rd_tick, rd_en, offset,
    output rd_data, count, empty_n, full_n, aempty_n, afull_n
  );
  modport user (
    output wr_tick, wr_en, wr_data, rd_tick, rd_en, offset,
    input rd_data, count, empty_n, full_n, aempty_n, afull_n
  );
endinterface

// ==== design/tpf_parity.sv ====
// Per-lane parity checker and generator for a bus of 9-bit lanes
`timescale 1ns/1ps
module tpf_parity #(
  parameter int unsigned LANES = 4
) (
  // Bus and polarity
  input wire logic [LANES*9-1:0] data,
  input wire logic odd,
  // Results
  output logic [LANES-1:0] lane_ok,
  output logic [LANES*9-1:0] with_parity
);
  localparam int unsigned LW = tpf_pkg::LANE_W;

  if (LANES == 0) begin : g_bad
    $error("tpf_parity needs at least one lane");
  end

  // Top bit of each lane is its parity bit
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_ok[i] = tpf_pkg::lane_ok(data[i*LW +: LW], odd);
    assign with_parity[i*LW +: LW] = {tpf_pkg::gen_bit(data[i*LW +: LW-1], odd),
                                      data[i*LW +: LW-1]};
  end
endmodule // tpf_parity

// ==== design/tpf_queue.sv ====
// One storage queue with port-timed two-stage empty and full flags
`timescale 1ns/1ps
module tpf_queue #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Queue connection
  tpf_queue_if.queue q
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  if ((DEPTH < tpf_pkg::MIN_DEPTH) || ((1 << AW) != DEPTH)) begin : g_bad
    $error("tpf_queue depth must be a power of two above the largest offset");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic empty_s1_q;
  logic full_s1_q;
  logic empty_n_q;
  logic full_n_q;
  logic aempty_n_q;
  logic afull_n_q;
  logic wr_fire;
  logic rd_fire;

  // Flags gate the transfers, so a stale flag can only hold data back
  assign wr_fire = q.wr_tick & q.wr_en & full_n_q;
  assign rd_fire = q.rd_tick & q.rd_en & empty_n_q;

  // Occupancy after this cycle's transfers
  always_comb begin
    count_d = count_q;
    if (wr_fire && !rd_fire) begin
      count_d = count_q + CW'(1);
    end else if (rd_fire && !wr_fire) begin
      count_d = count_q - CW'(1);
    end
  end

  // Storage, no reset needed on the array
  always_ff @(posedge pclk) begin
    if (wr_fire) begin
      mem[wr_ptr_q] <= q.wr_data;
    end
  end

  // Pointers and count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (wr_fire) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (rd_fire) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      count_q <= count_d;
    end
  end

  // Read-side flags: falling is immediate, rising takes two read-port edges for empty and one for almost-empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_s1_q <= 1'b0;
      empty_n_q <= 1'b0;
      aempty_n_q <= 1'b0;
    end else if (q.rd_tick) begin
      empty_s1_q <= count_d != '0;
      empty_n_q <= empty_s1_q & (count_d != '0);
      aempty_n_q <= count_d > q.offset;
    end
  end

  // Write-side flags: same scheme on the write-port edges, two-stage for full and one stage for almost-full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_s1_q <= 1'b0;
      full_n_q <= 1'b0;
      afull_n_q <= 1'b1;
    end else if (q.wr_tick) begin
      full_s1_q <= count_d != DEPTH_C;
      full_n_q <= full_s1_q & (count_d != DEPTH_C);
      afull_n_q <= (DEPTH_C - count_d) > q.offset;
    end
  end

  assign q.rd_data = mem[rd_ptr_q];
  assign q.count = count_q;
  assign q.empty_n = empty_n_q;
  assign q.full_n = full_n_q;
  assign q.aempty_n = aempty_n_q;
  assign q.afull_n = afull_n_q;

  // Full flag waits for two write-port edges after reset
  logic [1:0] wr_ticks_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ticks_q <= 2'h0;
    end else if (q.wr_tick && wr_ticks_q != 2'h3) begin
      wr_ticks_q <= wr_ticks_q + 2'h1;
    end
  end

  a_full_after_reset: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ticks_q < 2'h2) |-> !full_n_q) else $error("full flag rose too early");

  a_empty_two_ticks: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(empty_n_q) |-> $past(empty_s1_q) && $past(q.rd_tick))
    else $error("empty flag skipped its first stage");
endmodule // tpf_queue

// ==== design/tpf_top.sv ====
// Triple port dual queue: port timing, flags, offsets, parity and APB status
//
// Functional notes
// - Port C almost-full low when free space within offset
// - Port B 18-bit output, port C 18-bit input
// - Port A transfers and flags move on its edge; code updates the parity error flag on every pclk
// - Port B reads and flags move on its edge
// - Port C writes and flags move on its edge
// - Port A needs select low; otherwise drivers float
// - Port A also needs enable high at edge
// - Port A empty low blocks reads from queue
// - Port A empty resets low, rises second edge
// - Port B empty low blocks port B reads; code still sends the held high half of a read word
// - Port B empty resets low, rises second edge
// - Port A full low ignores port A writes
// - Port A full rises second edge after reset
// - Port C full low ignores port C writes
// - Port C full rises second edge after reset
// - Offset selects caught at reset release, then kept
// - Polarity input picks odd or even parity
// - Any failing port A lane drops error flag
// - Generated read on port A forces error high
// - Reset: almost-full and parity error high, other flags low
// - Offsets selectable as 4, 8, 12, 16
// - Direction high writes, low reads; high floats
// - Almost-empty low when count within offset
`timescale 1ns/1ps
module tpf_top #(
  parameter int unsigned DEPTH = tpf_pkg::QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Common straps
  input wire logic offset_select_lo,
  input wire logic offset_select_hi,
  input wire logic parity_odd,
  // Port A
  input wire logic port_a_clock,
  input wire logic port_a_select_n,
  input wire logic port_a_transfer_enable,
  input wire logic port_a_direction,
  input wire logic port_a_parity_generate,
  input wire logic [35:0] port_a_data_i,
  output logic [35:0] port_a_data_o,
  output logic port_a_data_oe,
  output logic port_a_empty_n,
  output logic port_a_full_n,
  output logic port_a_almost_empty_n,
  output logic port_a_almost_full_n,
  output logic port_a_parity_error_n,
  // Port B
  input wire logic port_b_clock,
  input wire logic port_b_read_enable,
  output logic [17:0] port_b_data,
  output logic port_b_empty_n,
  output logic port_b_almost_empty_n,
  // Port C
  input wire logic port_c_clock,
  input wire logic port_c_write_enable,
  input wire logic [17:0] port_c_data,
  output logic port_c_full_n,
  output logic port_c_almost_full_n
);
  localparam int unsigned AW_ = tpf_pkg::A_W;
  localparam int unsigned HW = tpf_pkg::HALF_W;
  localparam int unsigned CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  if (DEPTH < tpf_pkg::MIN_DEPTH || DEPTH > 32768 || AW_ != 2 * HW) begin : g_bad
    $error("tpf_top depth out of range for the 16-bit count fields");
  end

  tpf_queue_if #(.WIDTH(AW_), .DEPTH(DEPTH)) ab_q ();
  tpf_queue_if #(.WIDTH(AW_), .DEPTH(DEPTH)) ca_q ();

  logic a_clk_q;
  logic b_clk_q;
  logic c_clk_q;
  logic a_edge;
  logic b_edge;
  logic c_edge;
  logic a_go;
  logic [CW-1:0] offset_q;
  logic offset_taken_q;
  logic par_ignore_q;
  logic b_half_q;
  logic [HW-1:0] b_hi_q;
  logic [HW-1:0] b_data_q;
  logic c_half_q;
  logic [HW-1:0] c_lo_q;
  logic [35:0] a_data_q;
  logic a_oe_q;
  logic a_perr_n_q;
  logic [3:0] a_lane_ok;
  logic [35:0] a_gen_data;
  logic a_gen_force;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Port clocks arrive as sampled levels; a rising sample is a port edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
      c_clk_q <= 1'b0;
    end else begin
      a_clk_q <= port_a_clock;
      b_clk_q <= port_b_clock;
      c_clk_q <= port_c_clock;
    end
  end

  assign a_edge = port_a_clock & ~a_clk_q;
  assign b_edge = port_b_clock & ~b_clk_q;
  assign c_edge = port_c_clock & ~c_clk_q;

  // Offset straps cannot be loaded by the async reset, so take them at the first edge after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_q <= CW'(tpf_pkg::OFFSET_RESET);
      offset_taken_q <= 1'b0;
    end else if (!offset_taken_q) begin
      offset_q <= CW'(tpf_pkg::offset_of({offset_select_hi, offset_select_lo}));
      offset_taken_q <= 1'b1;
    end
  end

  // Port A qualifier: select low and enable high at the edge
  assign a_go = ~port_a_select_n & port_a_transfer_enable;

  // A-to-B queue: written from port A, drained by port B
  assign ab_q.wr_tick = a_edge;
  assign ab_q.wr_en = a_go & port_a_direction;
  assign ab_q.wr_data = port_a_data_i;
  assign ab_q.rd_tick = b_edge;
  assign ab_q.rd_en = port_b_read_enable & ~b_half_q;
  assign ab_q.offset = offset_q;

  // C-to-A queue: filled by port C word pairs, drained by port A
  assign ca_q.wr_tick = c_edge;
  assign ca_q.wr_en = port_c_write_enable & c_half_q;
  assign ca_q.wr_data = {port_c_data, c_lo_q};
  assign ca_q.rd_tick = a_edge;
  assign ca_q.rd_en = a_go & ~port_a_direction;
  assign ca_q.offset = offset_q;

  tpf_queue #(.WIDTH(AW_), .DEPTH(DEPTH)) u_ab (
    .pclk(pclk),
    .presetn(presetn),
    .q(ab_q.queue)
  );

  tpf_queue #(.WIDTH(AW_), .DEPTH(DEPTH)) u_ca (
    .pclk(pclk),
    .presetn(presetn),
    .q(ca_q.queue)
  );

  // Checker on the bus and generator on the outgoing word share one polarity input
  tpf_parity #(.LANES(tpf_pkg::A_LANES)) u_par_chk (
    .data(port_a_data_i),
    .odd(parity_odd),
    .lane_ok(a_lane_ok),
    .with_parity()
  );

  tpf_parity #(.LANES(tpf_pkg::A_LANES)) u_par_gen (
    .data(ca_q.rd_data),
    .odd(parity_odd),
    .lane_ok(),
    .with_parity(a_gen_data)
  );

  // Port A read register loads only on a granted read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_data_q <= '0;
    end else if (a_edge && ca_q.rd_en && ca_q.empty_n) begin
      a_data_q <= port_a_parity_generate ? a_gen_data : ca_q.rd_data;
    end
  end

  // Drivers on only while selected for a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_oe_q <= 1'b0;
    end else begin
      a_oe_q <= ~port_a_select_n & ~port_a_direction;
    end
  end

  // Generation has its own parity instance, yet the error flag is still forced high then
  assign a_gen_force = ~port_a_direction & port_a_parity_generate;

  // Passive error flag, may be masked by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_perr_n_q <= 1'b1;
    end else begin
      a_perr_n_q <= a_gen_force | par_ignore_q | (&a_lane_ok);
    end
  end

  // Port B: each 36-bit word leaves as low half then high half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_half_q <= 1'b0;
      b_hi_q <= '0;
      b_data_q <= '0;
    end else if (b_edge && port_b_read_enable) begin
      if (b_half_q) begin
        b_data_q <= b_hi_q;
        b_half_q <= 1'b0;
      end else if (ab_q.empty_n) begin
        b_data_q <= ab_q.rd_data[HW-1:0];
        b_hi_q <= ab_q.rd_data[AW_-1:HW];
        b_half_q <= 1'b1;
      end
    end
  end

  // Port C: low half is held, the high half completes the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_half_q <= 1'b0;
      c_lo_q <= '0;
    end else if (c_edge && port_c_write_enable && ca_q.full_n) begin
      if (!c_half_q) begin
        c_lo_q <= port_c_data;
      end
      c_half_q <= ~c_half_q;
    end
  end

  // Software control: parity flag mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_ignore_q <= tpf_pkg::CTRL_RESET[tpf_pkg::CTRL_PAR_IGNORE_BIT];
    end else if (psel && penable && pready_q && pwrite && paddr == tpf_pkg::ADDR_CTRL) begin
      par_ignore_q <= pwdata[tpf_pkg::CTRL_PAR_IGNORE_BIT];
    end
  end

  // APB answer one cycle into the access phase; data captured with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel && penable && !pready_q) begin
        prdata_q <= '0;
        pslverr_q <= 1'b0;
        unique case (paddr)
          tpf_pkg::ADDR_CTRL: begin
            prdata_q[tpf_pkg::CTRL_PAR_IGNORE_BIT] <= par_ignore_q;
          end
          tpf_pkg::ADDR_STATUS: begin
            if (!pwrite) begin
              prdata_q[tpf_pkg::ST_A_EMPTY_BIT] <= ca_q.empty_n;
              prdata_q[tpf_pkg::ST_A_FULL_BIT] <= ab_q.full_n;
              prdata_q[tpf_pkg::ST_A_AEMPTY_BIT] <= ca_q.aempty_n;
              prdata_q[tpf_pkg::ST_A_AFULL_BIT] <= ab_q.afull_n;
              prdata_q[tpf_pkg::ST_B_EMPTY_BIT] <= ab_q.empty_n;
              prdata_q[tpf_pkg::ST_B_AEMPTY_BIT] <= ab_q.aempty_n;
              prdata_q[tpf_pkg::ST_C_FULL_BIT] <= ca_q.full_n;
              prdata_q[tpf_pkg::ST_C_AFULL_BIT] <= ca_q.afull_n;
              prdata_q[tpf_pkg::ST_PAR_ERR_BIT] <= a_perr_n_q;
              prdata_q[tpf_pkg::ST_OFFSET_LSB +: CW] <= offset_q;
            end
          end
          tpf_pkg::ADDR_COUNT: begin
            if (!pwrite) begin
              prdata_q[tpf_pkg::CNT_AB_LSB +: CW] <= ab_q.count;
              prdata_q[tpf_pkg::CNT_CA_LSB +: CW] <= ca_q.count;
            end
          end
          default: begin
            pslverr_q <= 1'b1; // Unmapped address
          end
        endcase
      end
    end
  end

  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign port_a_data_o = a_data_q;
  assign port_a_data_oe = a_oe_q;
  assign port_a_empty_n = ca_q.empty_n;
  assign port_a_full_n = ab_q.full_n;
  assign port_a_almost_empty_n = ca_q.aempty_n;
  assign port_a_almost_full_n = ab_q.afull_n;
  assign port_a_parity_error_n = a_perr_n_q;
  assign port_b_data = b_data_q;
  assign port_b_empty_n = ab_q.empty_n;
  assign port_b_almost_empty_n = ab_q.aempty_n;
  assign port_c_full_n = ca_q.full_n;
  assign port_c_almost_full_n = ca_q.afull_n;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_full_blocks_write: assert property ((a_edge && a_go && port_a_direction && !port_a_full_n)
    |=> ab_q.count <= $past(ab_q.count)) else $error("write passed a full flag");
  a_empty_blocks_read: assert property ((a_edge && a_go && !port_a_direction && !port_a_empty_n)
    |=> $stable(port_a_data_o)) else $error("read passed an empty flag");
  a_select_floats: assert property (port_a_select_n |=> !port_a_data_oe)
    else $error("port A driven while deselected");
  a_dir_floats: assert property (port_a_direction |=> !port_a_data_oe)
    else $error("port A driven during write");
  a_gen_forces_flag: assert property (a_gen_force |=> port_a_parity_error_n)
    else $error("parity flag not forced high");
  a_lane_fail_flag: assert property ((!a_gen_force && !par_ignore_q
    && (^port_a_data_i[35:27] != parity_odd)) |=> !port_a_parity_error_n)
    else $error("bad lane not flagged");
  a_a_flag_edge: assert property ($changed(port_a_full_n) || $changed(port_a_empty_n)
    |-> $past(a_edge)) else $error("port A flag moved off its edge");
  a_b_flag_edge: assert property ($changed(port_b_empty_n) |-> $past(b_edge))
    else $error("port B flag moved off its edge");
  a_c_flag_edge: assert property ($changed(port_c_full_n) |-> $past(c_edge))
    else $error("port C flag moved off its edge");
  a_c_afull_level: assert property (c_edge
    |=> port_c_almost_full_n == ((DEPTH_C - ca_q.count) > offset_q))
    else $error("port C almost-full wrong");
  a_b_aempty_level: assert property (b_edge |=> port_b_almost_empty_n == (ab_q.count > offset_q))
    else $error("port B almost-empty wrong");
  a_offset_kept: assert property (offset_taken_q |=> $stable(offset_q) && offset_taken_q)
    else $error("offset changed after reset");
  a_b_empty_blocks: assert property ((b_edge && port_b_read_enable && !b_half_q
    && !port_b_empty_n) |=> ab_q.count >= $past(ab_q.count))
    else $error("port B read passed empty flag");
endmodule // tpf_top

// ==== verification/tpf_far_clocks.sv ====
// Far-side clock source for the three queue ports
`timescale 1ns/1ps
module tpf_far_clocks (
  // System clock
  input wire logic pclk,
  // Port clocks
  output logic clk_a,
  output logic clk_b,
  output logic clk_c
);
  logic [1:0] n_q = 2'h0;
  // Free running, never stopped, each phase one pclk or more so no edge is lost
  always @(posedge pclk) begin
    n_q <= n_q + 2'h1;
  end
  // Port B runs slower than A and C to vary the edge spacing
  assign clk_a = n_q[0];
  assign clk_b = n_q[1];
  assign clk_c = ~n_q[0];
endmodule // tpf_far_clocks

// ==== verification/testbench.sv ====
// Self-checking bench for the triple port queue block
`timescale 1ns/1ps
module testbench;
  localparam logic [35:0] M = 36'h1ffffffff;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] pwdata = 32'h0, prdata;
  logic fs_lo = 1'b0, fs_hi = 1'b0, odd = 1'b0;
  logic a_sel_n = 1'b1, a_en = 1'b0, a_dir = 1'b1, a_pg = 1'b0;
  logic [35:0] a_di = 36'h0, a_do, w, v, q, mw, mv;
  logic a_oe, a_ef, a_ff, a_ae, a_af, a_pe, oe, b_ren = 1'b0, b_ef, b_ae;
  logic [17:0] b_do, h, c_di = 18'h0;
  logic c_we = 1'b0, c_ff, c_af, clk_a, clk_b, clk_c;
  logic [1:0] sel;
  int errors = 0, compares = 0, seed = 99, off;
  logic [35:0] exp_q[$], msk_q[$];

  tpf_far_clocks u_far (.pclk(pclk), .clk_a(clk_a), .clk_b(clk_b), .clk_c(clk_c));
  tpf_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .offset_select_lo(fs_lo), .offset_select_hi(fs_hi), .parity_odd(odd),
    .port_a_clock(clk_a), .port_a_select_n(a_sel_n), .port_a_transfer_enable(a_en),
    .port_a_direction(a_dir), .port_a_parity_generate(a_pg), .port_a_data_i(a_di),
    .port_a_data_o(a_do), .port_a_data_oe(a_oe), .port_a_empty_n(a_ef), .port_a_full_n(a_ff),
    .port_a_almost_empty_n(a_ae), .port_a_almost_full_n(a_af), .port_a_parity_error_n(a_pe),
    .port_b_clock(clk_b), .port_b_read_enable(b_ren), .port_b_data(b_do),
    .port_b_empty_n(b_ef), .port_b_almost_empty_n(b_ae), .port_c_clock(clk_c),
    .port_c_write_enable(c_we), .port_c_data(c_di), .port_c_full_n(c_ff),
    .port_c_almost_full_n(c_af));

  // System clock
  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // APB master; a zero mask marks a write with nothing to compare, e carries its data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [35:0] e,
      input logic [35:0] m);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= e[31:0];
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge pclk);
    penable <= 1'b1;
    // No answer time is assumed; only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Set up in the low phase, hold through the sampled port edge, then release
  task automatic pa(input logic dir, input logic sn, input logic en, input logic [35:0] d);
    wait (clk_a === 1'b0);
    @(posedge pclk);
    a_dir <= dir;
    a_sel_n <= sn;
    a_en <= en;
    a_di <= d;
    @(posedge clk_a);
    @(posedge pclk);
    #1;
    q = a_do;
    oe = a_oe;
    @(posedge pclk);
    a_en <= 1'b0;
    a_sel_n <= 1'b1;
  endtask

  task automatic pb();
    wait (clk_b === 1'b0);
    @(posedge pclk);
    b_ren <= 1'b1;
    @(posedge clk_b);
    @(posedge pclk);
    #1;
    h = b_do;
    @(posedge pclk);
    b_ren <= 1'b0;
  endtask

  task automatic pc(input logic [17:0] d);
    wait (clk_c === 1'b0);
    @(posedge pclk);
    c_we <= 1'b1;
    c_di <= d;
    @(posedge clk_c);
    @(posedge pclk);
    @(posedge pclk);
    c_we <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Each APB answer is taken against the oldest note, read data with the error bit
  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0) begin
      mw = exp_q.pop_front();
      mv = msk_q.pop_front();
      if (mv != 36'h0) chk({3'h0, pslverr, prdata} & mv, mw);
    end
  end

  // Cut a hang short
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    sel = 2'($random(seed));
    fs_lo <= sel[0];
    fs_hi <= sel[1];
    off = (sel + 1) * 4;
    // Reset spans four edges of the slowest port clock, so every port sees at least four
    repeat (4) @(posedge clk_b);
    @(posedge pclk);
    chk({a_ff, a_af, c_ff, c_af, a_ef, b_ef, a_ae, b_ae, a_oe, a_pe}, 36'h141);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b0, tpf_pkg::ADDR_STATUS, {13'h0, 7'(off), 16'h01ca}, M);
    apb(1'b0, 12'h010, 36'h100000000, M);
    w[31:0] = $random(seed);
    w[35:32] = 4'($random(seed));
    pa(1'b1, 1'b1, 1'b1, w ^ 36'hf);
    pa(1'b1, 1'b0, 1'b0, w ^ 36'hf0);
    pa(1'b1, 1'b0, 1'b1, w);
    repeat (10) @(posedge pclk);
    apb(1'b0, tpf_pkg::ADDR_COUNT, 36'h1, M);
    pb();
    chk(h, w[17:0]);
    pb();
    chk(h, w[35:18]);
    pb();
    chk({b_ef, h}, {1'b0, w[35:18]});
    v[31:0] = $random(seed);
    v[35:32] = 4'($random(seed));
    pc(v[17:0]);
    pc(v[35:18]);
    repeat (10) @(posedge pclk);
    chk(a_ef, 36'h1);
    pa(1'b0, 1'b0, 1'b1, 36'h0);
    chk(oe, 36'h1);
    chk(q, v);
    pa(1'b0, 1'b0, 1'b1, 36'h0);
    chk(a_ef, 36'h0);
    chk(q, v);
    // Drivers drop one cycle after the deselect is seen
    repeat (2) @(posedge pclk);
    chk(a_oe, 36'h0);
    // Fill the C-to-A queue past full; the almost-full boundary is checked on the way
    for (int i = 1; i <= 65; i++) begin
      pc(18'(i));
      pc(18'(i));
      if (i >= 63 - off && i <= 64 - off) chk(c_af, 36'(i == 63 - off));
    end
    chk(c_ff, 36'h0);
    // Fill the A-to-B queue past full from port A; the extra write must be dropped
    for (int i = 0; i < 65; i++) begin
      pa(1'b1, 1'b0, 1'b1, 36'(i));
    end
    chk({a_ff, a_af}, 36'h0);
    apb(1'b0, tpf_pkg::ADDR_COUNT, 36'h400040, M);
    chk(a_ae, 36'h1);
    // Generated read of word {1, 1}: even parity bits land in lanes 0 and 2
    a_pg <= 1'b1;
    pa(1'b0, 1'b0, 1'b1, 36'h0);
    chk(q, 36'h004040101);
    chk(a_pe, 36'h1);
    // Bad lanes under both polarities, good lanes under odd, then the generated-read override
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      odd <= (i > 0);
      a_dir <= (i < 3);
      a_pg <= (i == 3);
      a_di <= (i < 2) ? 36'h008040201 : 36'h008040200;
      repeat (3) @(posedge pclk);
      chk(a_pe, 36'(i % 2));
    end
    // Software mask holds the flag high over a failing lane, then lets it fall again
    a_pg <= 1'b0;
    apb(1'b1, tpf_pkg::ADDR_CTRL, 36'h1, 36'h0);
    apb(1'b0, tpf_pkg::ADDR_CTRL, 36'h1, M);
    repeat (3) @(posedge pclk);
    chk(a_pe, 36'h1);
    apb(1'b1, tpf_pkg::ADDR_CTRL, 36'h0, 36'h0);
    repeat (3) @(posedge pclk);
    chk(a_pe, 36'h0);
    end_of_test();
  end
endmodule // testbench
